// ---- rtl/gsfp_regs.svh ----
// Offsets, field positions, reset values and counts for gain/fault control.
// Assumes a 50 MHz system clock and the plain register port of the top.
`ifndef GSFP_REGS_SVH
`define GSFP_REGS_SVH

// ==========================================================================
// Register offsets
`define GSFP_OFF_STATUS 4'h0
`define GSFP_OFF_MASK 4'h1
`define GSFP_OFF_FLAGS 4'h2
`define GSFP_OFF_GAIN 4'h3

// ==========================================================================
// Status and mask field positions
`define GSFP_BIT_OC 0
`define GSFP_BIT_OT 1
`define GSFP_BIT_UV 2
`define GSFP_BIT_CLR 3
`define GSFP_EV_W 4

// ==========================================================================
// Reset values and timing
`define GSFP_MASK_RST 4'h0
`define GSFP_GAIN_RST 2'h0
`define GSFP_POR_NS 1000
`define GSFP_CLK_NS 20
`define GSFP_POR_CYC ((`GSFP_POR_NS + `GSFP_CLK_NS - 1) / `GSFP_CLK_NS)

`endif

// ---- rtl/gsfp_pkg.sv ----
// Types shared by the gain and fault control block.
// Assumes the constants header is included by users that need offsets.
`default_nettype none

package gsfp_pkg;
  // ========================================================================
  // Supervisor states, one-hot
  typedef enum logic [2:0] {
    GSFP_ST_POR = 3'b001,
    GSFP_ST_RUN = 3'b010,
    GSFP_ST_TRIP = 3'b100
  } gsfp_state_t;

  // Channel gain in dB steps
  typedef enum logic [1:0] {
    GSFP_G0DB = 2'h0,
    GSFP_G6DB = 2'h1,
    GSFP_G12DB = 2'h2,
    GSFP_G18DB = 2'h3
  } gsfp_gain_t;
endpackage

`default_nettype wire

// ---- rtl/gsfp_sync.sv ----
// Two-stage synchroniser for a bus of asynchronous detector levels.
// Assumes one system clock and asynchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module gsfp_sync #(
  parameter int WIDTH = 4
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] stage1;

  // ========================================================================
  // First stage only feeds the second stage
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      stage1 <= '0;
      o_sync <= '0;
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end
endmodule // gsfp_sync

`default_nettype wire

// ---- rtl/gsfp_top.sv ----
// Gain capture and fault protection supervisor of a class-D amplifier.
// Assumes detector inputs are asynchronous levels, active high, and that
// the gain pins are static while the reset pin is high.
`timescale 1ns/1ps
`default_nettype none
`include "gsfp_regs.svh"

// Behaviour
// - Gain pins are captured at each rising edge of the reset pin.
// - Code 00/01/10/11 gives 0/6/12/18 dB, GAIN_1 as upper bit.
// - One gain value drives all channels; no per-channel gain.
// - Any fault puts the power stage in high impedance; fault pin low once power-on clear is done.
// - When faults other than overcurrent clear, operation resumes and the fault pin releases.
// - Each high-side and low-side transistor has its own detector input.
// - Overcurrent causes latched shutdown: high impedance and fault low.
// - Overcurrent on either bridge pair shuts down all four half-bridges.
// - Overtemperature flag trips outputs; recovery when flag falls.
// - Undervoltage on any supply trips outputs immediately.
// - Undervoltage recovery only once every supply is good again.
// - Power-on clear resets protection and holds until supplies are up.
module gsfp_top #(
  parameter int N_HB = 4,
  parameter int N_SUP = 3,
  parameter int POR_CYC = `GSFP_POR_CYC
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RESET,
  input wire logic i_amp_reset,
  input wire logic i_gain_0,
  input wire logic i_gain_1,
  input wire logic [N_HB-1:0] i_oc_high,
  input wire logic [N_HB-1:0] i_oc_low,
  input wire logic i_overtemp,
  input wire logic [N_SUP-1:0] i_supply_ok,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic [1:0] o_gain_code,
  output logic [N_HB-1:0] o_hb_hiz,
  output logic o_fault_n,
  output logic o_irq
);
  localparam int NDET = 2 * N_HB + 1 + N_SUP;

  // ========================================================================
  // Detector synchronisation
  logic [NDET-1:0] det_sync;
  logic oc_any;
  logic ot_now;
  logic uv_now;
  logic sup_all_ok;

  gsfp_sync #(
    .WIDTH(NDET)
  ) u_sync (
    .i_clk(I_SYS_CLK),
    .i_rst(I_RESET),
    .i_async({i_supply_ok, i_overtemp, i_oc_low, i_oc_high}),
    .o_sync(det_sync)
  );

  // Any transistor detector of any half-bridge counts as overcurrent
  assign oc_any = |det_sync[2*N_HB-1:0];
  assign ot_now = det_sync[2*N_HB];
  // Supply bits reset low, so the block starts out as if undervoltage
  assign sup_all_ok = &det_sync[NDET-1:2*N_HB+1];
  assign uv_now = ~sup_all_ok;

  // ========================================================================
  // Gain capture on the amplifier reset pin's rising edge
  logic amp_rst_d;
  gsfp_pkg::gsfp_gain_t gain;

  // Pin level one cycle back; resets low, the pin's idle level, so no
  // false capture edge follows reset
  always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      amp_rst_d <= 1'b0;
    end else begin
      amp_rst_d <= i_amp_reset;
    end
  end

  // Code held until the next rising edge; pins steady while high
  always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      gain <= gsfp_pkg::GSFP_G0DB;
    end else if (i_amp_reset && !amp_rst_d) begin
      gain <= gsfp_pkg::gsfp_gain_t'({i_gain_1, i_gain_0});
    end
  end

  // Single gain shared by every channel
  assign o_gain_code = gain;

  // ========================================================================
  // Power-on clear counter
  logic [15:0] por_cnt;
  logic por_done;

  // Counts only while supplies are good; restarts on any dip before done
  // Once done it stops; a later dip is the undervoltage trip's business
  always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      por_cnt <= 16'h0000;
    end else if (!sup_all_ok && !por_done) begin
      por_cnt <= 16'h0000;
    end else if (!por_done) begin
      por_cnt <= por_cnt + 16'h0001;
    end
  end
  assign por_done = (por_cnt >= 16'(POR_CYC));

  // ========================================================================
  // Protection supervisor
  gsfp_pkg::gsfp_state_t state;
  gsfp_pkg::gsfp_state_t next_state;
  logic oc_latch;
  logic clr_req;

  // One place decides what counts as a live fault for every state
  function automatic logic fault_live(input logic oc, input logic ot,
                                      input logic uv);
    return oc || ot || uv;
  endfunction

  // Overcurrent latch: set wins over the software clear
  // so a short that persists cannot be cleared by a polling loop
  always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      oc_latch <= 1'b0;
    end else if (!por_done) begin
      oc_latch <= 1'b0;
    end else if (oc_any) begin
      oc_latch <= 1'b1;
    end else if (clr_req) begin
      oc_latch <= 1'b0;
    end
  end

  // Trip on any live fault; stay tripped while an overcurrent is latched
  always_comb begin
    next_state = state;
    case (state)
      gsfp_pkg::GSFP_ST_POR: begin
        // A fault present as the clear ends must not open the outputs
        if (por_done && fault_live(oc_any, ot_now, uv_now)) begin
          next_state = gsfp_pkg::GSFP_ST_TRIP;
        end else if (por_done) begin
          next_state = gsfp_pkg::GSFP_ST_RUN;
        end
      end
      gsfp_pkg::GSFP_ST_RUN: begin
        if (fault_live(oc_any, ot_now, uv_now)) begin
          next_state = gsfp_pkg::GSFP_ST_TRIP;
        end
      end
      gsfp_pkg::GSFP_ST_TRIP: begin
        if (!oc_latch && !fault_live(oc_any, ot_now, uv_now)) begin
          next_state = gsfp_pkg::GSFP_ST_RUN;
        end
      end
      default: next_state = gsfp_pkg::GSFP_ST_POR;
    endcase
  end

  // State register
  always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      state <= gsfp_pkg::GSFP_ST_POR;
    end else begin
      state <= next_state;
    end
  end

  // Outputs from flops fed by next_state; a fault seen this cycle forces them at the next edge
  logic stop;
  assign stop = (next_state != gsfp_pkg::GSFP_ST_RUN);

  // All half-bridges share one stop; no per-pair isolation
  always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      o_hb_hiz <= '1;
      o_fault_n <= 1'b1;
    end else begin
      o_hb_hiz <= {N_HB{stop}};
      // Fault pin follows the trip state only; power-on clear keeps it high
      o_fault_n <= (next_state != gsfp_pkg::GSFP_ST_TRIP);
    end
  end

  // ========================================================================
  // Event flags, mask and interrupt
  logic [`GSFP_EV_W-1:0] status;
  logic [`GSFP_EV_W-1:0] mask;
  logic [`GSFP_EV_W-1:0] ev;
  logic wr_status;
  logic in_run;

  assign in_run = (state == gsfp_pkg::GSFP_ST_RUN);
  assign ev[`GSFP_BIT_OC] = oc_any && por_done;
  assign ev[`GSFP_BIT_OT] = ot_now && por_done;
  assign ev[`GSFP_BIT_UV] = uv_now && por_done;
  assign ev[`GSFP_BIT_CLR] = (state == gsfp_pkg::GSFP_ST_TRIP)
                             && (next_state == gsfp_pkg::GSFP_ST_RUN);
  assign wr_status = i_wr && (i_addr == `GSFP_OFF_STATUS);

  // Write one clears; a new event in the same cycle wins
  always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      status <= '0;
    end else begin
      status <= (status & ~(wr_status ? i_wdata[`GSFP_EV_W-1:0] : '0)) | ev;
    end
  end

  // Mask register, plain read and write
  always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      mask <= `GSFP_MASK_RST;
    end else if (i_wr && i_addr == `GSFP_OFF_MASK) begin
      mask <= i_wdata[`GSFP_EV_W-1:0];
    end
  end

  // Clearing the overcurrent flag re-arms the latched shutdown
  assign clr_req = wr_status && i_wdata[`GSFP_BIT_OC];

  // Level interrupt decoded from the status and mask flops, not registered
  assign o_irq = |(status & mask);

  // ========================================================================
  // Register read port, data one cycle after the strobe
  // Reads have no side effect, so polling cannot lose an event
  always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        `GSFP_OFF_STATUS: o_rdata <= {4'h0, status};
        `GSFP_OFF_MASK: o_rdata <= {4'h0, mask};
        `GSFP_OFF_FLAGS: o_rdata <= {2'h0, in_run, por_done, oc_latch,
                                     uv_now, ot_now, oc_any};
        `GSFP_OFF_GAIN: o_rdata <= {6'h00, gain};
        default: o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // ========================================================================
  // Checks
  // Gain capture and hold
  gain_capture_a: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RESET)
    (i_amp_reset && !amp_rst_d) |=>
      (gain == {$past(i_gain_1), $past(i_gain_0)}))
    else $error("gain not captured on reset rising edge");

  gain_hold_a: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RESET)
    !(i_amp_reset && !amp_rst_d) |=> $stable(gain))
    else $error("gain changed without reset edge");

  gain_shared_a: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RESET)
    (i_amp_reset && !amp_rst_d) |=>
      (o_gain_code == {$past(i_gain_1), $past(i_gain_0)}))
    else $error("channel gain differs from captured code");

  // Trip and recovery of the power stage
  fault_hiz_a: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RESET)
    (por_done && (ot_now || uv_now)) |=> (&o_hb_hiz && !o_fault_n))
    else $error("fault did not stop outputs and pull fault low");

  oc_latched_a: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RESET)
    (in_run && oc_any) ##1 !clr_req [*6] |-> (&o_hb_hiz && !o_fault_n))
    else $error("overcurrent shutdown not latched");

  oc_all_bridges_a: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RESET)
    (por_done && oc_any) |=> (o_hb_hiz == '1))
    else $error("overcurrent did not stop all half-bridges");

  auto_resume_a: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RESET)
    (state == gsfp_pkg::GSFP_ST_TRIP && !oc_latch && !oc_any && !ot_now
     && !uv_now) |=> (o_fault_n && o_hb_hiz == '0))
    else $error("no recovery after faults cleared");

  uv_recover_a: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RESET)
    (state == gsfp_pkg::GSFP_ST_TRIP && uv_now) |=> !in_run)
    else $error("resumed while a supply was low");

  por_hold_a: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RESET)
    !por_done |=> (&o_hb_hiz && !oc_latch))
    else $error("outputs enabled before power-on clear ended");

  // Overcurrent latch, power-on clear, event flags and read port
  irq_level_a: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RESET)
    ev[`GSFP_BIT_OT] && mask[`GSFP_BIT_OT] |=> o_irq)
    else $error("masked-in event gave no interrupt");

  oc_refuse_a: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RESET)
    (por_done && oc_any && clr_req) |=> oc_latch)
    else $error("overcurrent clear taken while detector active");

  trip_hold_a: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RESET)
    (oc_latch && !clr_req) |=> !in_run)
    else $error("left latched shutdown without a clear");

  por_count_a: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RESET)
    (!por_done && !sup_all_ok) |=> (por_cnt == 16'h0000))
    else $error("power-on count kept running with a supply low");

  por_quiet_a: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RESET)
    !por_done |=> o_fault_n)
    else $error("fault pin pulled low during power-on clear");

  status_set_a: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RESET)
    (ev != '0) |=> ((status & $past(ev)) == $past(ev)))
    else $error("event lost although clear came in the same cycle");

  rdata_idle_a: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RESET)
    !i_rd |=> (o_rdata == 8'h00))
    else $error("read data seen without a read strobe");
endmodule // gsfp_top

`default_nettype wire

// ---- verif/gsfp_ctrl.sv ----
// Board controller model: drives the gain pins and the amplifier reset pin.
// Assumes the bench calls apply_gain from its own procedural thread.
`timescale 1ns/1ps
`default_nettype none

module gsfp_ctrl (
  input wire logic i_clk,
  output logic o_amp_reset,
  output logic o_gain_0,
  output logic o_gain_1
);
  // ==========================================================================
  // Pin drive
  // Idle with reset low and gain 0 until the bench asks for a capture
  initial begin
    o_amp_reset = 1'b0;
    o_gain_0 = 1'b0;
    o_gain_1 = 1'b0;
  end

  // Pins move only while reset is low, so the capture never sees a glitch
  task automatic apply_gain(input logic [1:0] code);
    @(posedge i_clk);
    o_amp_reset <= 1'b0;
    @(posedge i_clk);
    o_gain_1 <= code[1];
    o_gain_0 <= code[0];
    repeat (2) @(posedge i_clk);
    o_amp_reset <= 1'b1;
    repeat (3) @(posedge i_clk);
  endtask
endmodule // gsfp_ctrl

`default_nettype wire

// ---- verif/gain_select_fault_protection_test.sv ----
// Self-checking bench for the gain capture and fault supervisor.
// Assumes the controller model owns the gain and amplifier reset pins.
`timescale 1ns/1ps
`default_nettype none

module gain_select_fault_protection_test;
  // ==========================================================================
  // Signals and instances
  // Short power-on clear keeps the run brief
  localparam int POR = 4;
  logic clk, rst, amp_rst, g0, g1, ot, wr_s, rd_s, fault_n, irq;
  logic [3:0] och, ocl, hiz, addr;
  logic [2:0] sup;
  logic [7:0] wdata, rdata, d;
  logic [1:0] gain;
  int errors = 0;
  int samples_checked = 0;

  gsfp_top #(.POR_CYC(POR)) gsfp_top_i (.I_SYS_CLK(clk), .I_RESET(rst),
    .i_amp_reset(amp_rst), .i_gain_0(g0), .i_gain_1(g1), .i_oc_high(och),
    .i_oc_low(ocl), .i_overtemp(ot), .i_supply_ok(sup), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata),
    .o_gain_code(gain), .o_hb_hiz(hiz), .o_fault_n(fault_n), .o_irq(irq));
  gsfp_ctrl gsfp_ctrl_i (.i_clk(clk), .o_amp_reset(amp_rst), .o_gain_0(g0),
    .o_gain_1(g1));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ==========================================================================
  // Shared tasks
  task automatic chk(input string what, input logic [7:0] e,
                     input logic [7:0] s);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, s);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask

  // Detector change lands 3 edges later: 2 sync stages and the output flop
  task automatic edge3(input logic v);
    repeat (2) @(posedge clk);
    #1 chk("fault_n early", {7'h00, !v}, {7'h00, fault_n});
    @(posedge clk);
    #1 chk("fault_n", {7'h00, v}, {7'h00, fault_n});
    chk("hiz", {4'h0, {4{!v}}}, {4'h0, hiz});
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic sc_por();
    @(posedge clk);
    #1 chk("por hiz", 8'h0f, {4'h0, hiz});
    chk("por fault_n", 8'h01, {7'h00, fault_n});
    repeat (POR + 6) @(posedge clk);
    #1 chk("run hiz", 8'h00, {4'h0, hiz});
  endtask

  // Order 2,3,0,1 so every capture changes at least one bit
  task automatic sc_gain();
    for (int c = 0; c < 4; c++) begin
      gsfp_ctrl_i.apply_gain(2'(c ^ 2));
      chk("gain", 8'(c ^ 2), {6'h00, gain});
      rd(4'h3);
      chk("gain reg", 8'(c ^ 2), d);
    end
  endtask

  task automatic sc_ot();
    wr(4'h1, 8'h02);
    @(posedge clk);
    ot <= 1'b1;
    edge3(1'b0);
    chk("irq set", 8'h01, {7'h00, irq});
    @(posedge clk);
    ot <= 1'b0;
    edge3(1'b1);
    rd(4'h0);
    chk("status ot", 8'h02, d & 8'h02);
    wr(4'h1, 8'h00);
    @(posedge clk);
    #1 chk("irq masked", 8'h00, {7'h00, irq});
    wr(4'h1, 8'h02);
    wr(4'h0, 8'hff);
    @(posedge clk);
    #1 chk("irq cleared", 8'h00, {7'h00, irq});
    wr(4'h1, 8'h00);
  endtask

  // Two supplies low, one recovers: outputs must stay off
  task automatic sc_uv();
    @(posedge clk);
    sup <= 3'h5;
    edge3(1'b0);
    @(posedge clk);
    sup <= 3'h4;
    @(posedge clk);
    sup <= 3'h6;
    repeat (5) @(posedge clk);
    #1 chk("uv partial", 8'h00, {7'h00, fault_n});
    @(posedge clk);
    sup <= 3'h7;
    edge3(1'b1);
  endtask

  // Each of the eight transistor detectors alone stops all four bridges;
  // odd rounds also try a clear while the detector still fires
  task automatic sc_oc();
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      {och, ocl} <= 8'h01 << i;
      edge3(1'b0);
      if (i % 2 == 1) begin
        wr(4'h0, 8'h01);
      end
      @(posedge clk);
      {och, ocl} <= 8'h00;
      repeat (6) @(posedge clk);
      #1 chk("oc latch", 8'h00, {7'h00, fault_n});
      rd(4'h2);
      chk("flags latched", 8'h18, d);
      wr(4'h0, 8'h01);
      repeat (4) @(posedge clk);
      #1 chk("oc clear", 8'h01, {7'h00, fault_n});
    end
  endtask

  // Unmapped place reads zero and swallows writes; gain is read-only
  task automatic sc_map();
    rd(4'h9);
    chk("unmapped", 8'h00, d);
    wr(4'h9, 8'hff);
    wr(4'h3, 8'h00);
    rd(4'h1);
    chk("mask kept", 8'h00, d);
    rd(4'h3);
    chk("gain ro", 8'h01, d);
    rd(4'h2);
    chk("flags run", 8'h30, d);
    rd(4'h0);
    chk("status", 8'h0c, d);
  endtask

  // ==========================================================================
  // Main sequence and hang guard
  initial begin
    rst = 1'b1;
    och = 4'h0;
    ocl = 4'h0;
    ot = 1'b0;
    sup = 3'h7;
    addr = 4'h0;
    wdata = 8'h00;
    wr_s = 1'b0;
    rd_s = 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    sc_por();
    sc_gain();
    sc_ot();
    sc_uv();
    sc_oc();
    sc_map();
    conclude();
  end

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    $display("CHECK FAILED run length expected end seen hang");
    conclude();
  end
endmodule // gain_select_fault_protection_test

`default_nettype wire
